// [rtl/lcr_config_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "lcr_consts.vh"
// Functional notes
// RULE1: overcurrent detection runs only while first register bit 0 is set.
// RULE2: first register bit 1 picks resistor oscillator or external dimming clock on pin.
// RULE3: first register bit 2 makes lamp sync pin output (0) or input (1).
// RULE4: first register bit 3 makes dimming sync pin output (0) or input (1).
// RULE5: first register bit 4 puts dimming pwm (0) or ramp (1) on sync pin.
// RULE6: auto retry after faults unless first register bit 5 is set.
// RULE7: fault stops faulty channel only, or both when bit 6 set.
// RULE8: burst dimming pwm applied unless first register bit 7 is set.
// RULE9: user memory writes blocked unless second register bit 0 is set.
// RULE10: second register bits 2:1 choose one of four dimming clock ranges.
// RULE11: host must match range field to external dimming clock frequency.
// RULE12: registers at f4 and f5, nonvolatile shadowed; first resets to zero.
// RULE13: copy to nonvolatile memory only while shadow write block bit is clear.
module lcr_config_regs (
    input  wire       clk_sys,
    input  wire       reset,
    // register port from the serial interface
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output wire       reg_hit,
    input  wire       shadow_nv_write_block,
    // nonvolatile copy request
    output reg        nv_wr_req,
    output reg  [7:0] nv_wr_addr,
    output reg  [7:0] nv_wr_data,
    output wire       nv_busy,
    input  wire       nv_load,
    input  wire [7:0] nv_load_cfg1,
    input  wire [7:0] nv_load_cfg2,
    // user memory write gate
    input  wire       user_mem_wr_req,
    output wire       user_mem_wr_grant,
    // fault handling
    input  wire       overcurrent_raw,
    output wire       overcurrent_fault,
    input  wire [1:0] chan_fault,
    output wire [1:0] chan_disable,
    output wire       auto_retry_en,
    // dimming oscillator
    output wire       dim_osc_ext_clk,
    input  wire       dim_osc_pin,
    output wire       dim_ext_clk,
    output wire [1:0] dim_range,
    // lamp sync pin
    input  wire       lamp_freq_int,
    input  wire       lamp_sync_pin_i,
    output wire       lamp_sync_pin_o,
    output wire       lamp_sync_pin_oe,
    output wire       lamp_freq,
    // dimming sync pin
    input  wire       dim_pwm_int,
    input  wire       ramp_int,
    input  wire       dim_sync_pin_i,
    output wire       dim_sync_pin_o,
    output wire       dim_sync_pin_oe,
    output wire       burst_dimming_pwm
);
    // ----------------------------------------
    // register storage
    // ----------------------------------------
    reg  [7:0] lamp_control_config_1_ff;
    reg  [7:0] lamp_control_config_2_ff;
    reg  [7:0] nv_cnt_ff;
    wire       lamp_sync_s;
    wire       dim_sync_s;
    wire       dim_osc_s;
    wire       wr_cfg1;
    wire       wr_cfg2;

    // copy time kept as a 32-bit constant so the counter load is an explicit slice
    localparam [31:0] NV_WRITE_CYC = `LCR_NV_WRITE_CYC;

    // ----------------------------------------
    // address map and write mask helpers
    // ----------------------------------------
    // one address map shared by the write, hit and read paths
    function is_cfg1(input [7:0] addr);
        is_cfg1 = (addr == `LCR_ADDR_CFG1);
    endfunction

    function is_cfg2(input [7:0] addr);
        is_cfg2 = (addr == `LCR_ADDR_CFG2);
    endfunction

    // reserved bits of the second register never store a one
    function [7:0] cfg2_mask(input [7:0] data);
        cfg2_mask = data & `LCR_CFG2_WMASK;
    endfunction

    // write strobes and address hit
    assign wr_cfg1 = reg_wr && is_cfg1(reg_addr);
    assign wr_cfg2 = reg_wr && is_cfg2(reg_addr);
    assign reg_hit = is_cfg1(reg_addr) || is_cfg2(reg_addr);

    // writes win over a simultaneous nonvolatile load
    always @(posedge clk_sys) begin
        if (reset) begin
            lamp_control_config_1_ff <= `LCR_CFG1_RESET; // RULE12
            lamp_control_config_2_ff <= `LCR_CFG2_RESET;
        end else begin
            if (nv_load) begin
                lamp_control_config_1_ff <= nv_load_cfg1;
                lamp_control_config_2_ff <= cfg2_mask(nv_load_cfg2);
            end
            if (wr_cfg1)
                lamp_control_config_1_ff <= reg_wdata; // RULE12
            if (wr_cfg2)
                lamp_control_config_2_ff <= cfg2_mask(reg_wdata);
        end
    end

    // read data registered, unmapped reads give zero
    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `LCR_ADDR_CFG1: reg_rdata <= lamp_control_config_1_ff;
                `LCR_ADDR_CFG2: reg_rdata <= lamp_control_config_2_ff;
                default:        reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // nonvolatile copy of shadowed writes
    // ----------------------------------------
    // block sampled at the write; a write during a busy copy still updates ram
    always @(posedge clk_sys) begin
        if (reset) begin
            nv_wr_req  <= 1'b0;
            nv_wr_addr <= 8'h00;
            nv_wr_data <= 8'h00;
            nv_cnt_ff  <= 8'h00;
        end else begin
            nv_wr_req <= 1'b0;
            if (nv_cnt_ff != 8'h00)
                nv_cnt_ff <= nv_cnt_ff - 8'h01;
            if ((wr_cfg1 || wr_cfg2) && !shadow_nv_write_block && nv_cnt_ff == 8'h00) begin // RULE13
                nv_wr_req  <= 1'b1;
                nv_wr_addr <= reg_addr;
                nv_wr_data <= wr_cfg2 ? cfg2_mask(reg_wdata) : reg_wdata;
                nv_cnt_ff  <= NV_WRITE_CYC[7:0];
            end
        end
    end
    assign nv_busy = (nv_cnt_ff != 8'h00);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    lcr_sync2 u_sync_lamp (
        .clk_sys (clk_sys),
        .reset   (reset),
        .din     (lamp_sync_pin_i),
        .dout    (lamp_sync_s)
    );
    lcr_sync2 u_sync_dim (
        .clk_sys (clk_sys),
        .reset   (reset),
        .din     (dim_sync_pin_i),
        .dout    (dim_sync_s)
    );
    lcr_sync2 u_sync_osc (
        .clk_sys (clk_sys),
        .reset   (reset),
        .din     (dim_osc_pin),
        .dout    (dim_osc_s)
    );

    // ----------------------------------------
    // control field decode
    // ----------------------------------------
    // named fields keep the bit map in one place for the decode below
    wire       overcurrent_detect_en;
    wire       dim_osc_input_sel;
    wire       lamp_freq_source_sel;
    wire       dim_pwm_source_sel;
    wire       ramp_output_sel;
    wire       auto_retry_off;
    wire       fault_response_sel;
    wire       dim_pwm_off;
    wire       user_mem_write_allow;

    assign overcurrent_detect_en = lamp_control_config_1_ff[`LCR_OVERCURRENT_DETECT_EN];
    assign dim_osc_input_sel     = lamp_control_config_1_ff[`LCR_DIM_OSC_INPUT_SEL];
    assign lamp_freq_source_sel  = lamp_control_config_1_ff[`LCR_LAMP_FREQ_SOURCE_SEL];
    assign dim_pwm_source_sel    = lamp_control_config_1_ff[`LCR_DIM_PWM_SOURCE_SEL];
    assign ramp_output_sel       = lamp_control_config_1_ff[`LCR_RAMP_OUTPUT_SEL];
    assign auto_retry_off        = lamp_control_config_1_ff[`LCR_AUTO_RETRY_OFF];
    assign fault_response_sel    = lamp_control_config_1_ff[`LCR_FAULT_RESPONSE_SEL];
    assign dim_pwm_off           = lamp_control_config_1_ff[`LCR_DIM_PWM_OFF];
    assign user_mem_write_allow  = lamp_control_config_2_ff[`LCR_USER_MEM_WRITE_ALLOW];

    // overcurrent gated off, not just masked in status
    assign overcurrent_fault = overcurrent_raw & overcurrent_detect_en; // RULE1
    assign dim_osc_ext_clk   = dim_osc_input_sel; // RULE2
    // external clock seen only in external mode; resistor mode leaves it low
    assign dim_ext_clk = dim_osc_ext_clk & dim_osc_s; // RULE2
    assign dim_range = {lamp_control_config_2_ff[`LCR_DIM_RANGE_MSB],
                        lamp_control_config_2_ff[`LCR_DIM_RANGE_LSB]}; // RULE10

    // lamp sync pin direction and source
    assign lamp_sync_pin_oe = ~lamp_freq_source_sel; // RULE3
    assign lamp_sync_pin_o  = lamp_freq_int;
    assign lamp_freq = lamp_sync_pin_oe ? lamp_freq_int : lamp_sync_s; // RULE3

    // dimming sync pin direction and content
    assign dim_sync_pin_oe = ~dim_pwm_source_sel; // RULE4
    assign dim_sync_pin_o  = ramp_output_sel ? ramp_int : dim_pwm_int; // RULE5
    // dimming off holds lamps on continuously
    assign burst_dimming_pwm = dim_pwm_off ? 1'b1 :
                               (dim_sync_pin_oe ? dim_pwm_int : dim_sync_s); // RULE8 RULE4

    // fault response and retry
    assign auto_retry_en = ~auto_retry_off; // RULE6
    assign chan_disable  = fault_response_sel ? {2{|chan_fault}} : chan_fault; // RULE7

    // user memory write protection
    assign user_mem_wr_grant = user_mem_wr_req & user_mem_write_allow; // RULE9
endmodule
`default_nettype wire

// [rtl/lcr_consts.vh]
`ifndef LCR_CONSTS_VH
`define LCR_CONSTS_VH
// ----------------------------------------
// register addresses and reset values
// ----------------------------------------
`define LCR_ADDR_CFG1     8'hf4
`define LCR_ADDR_CFG2     8'hf5
`define LCR_CFG1_RESET    8'h00
`define LCR_CFG2_RESET    8'h08
`define LCR_CFG2_WMASK    8'h9f
// ----------------------------------------
// field positions, first register
// ----------------------------------------
`define LCR_OVERCURRENT_DETECT_EN 0
`define LCR_DIM_OSC_INPUT_SEL     1
`define LCR_LAMP_FREQ_SOURCE_SEL  2
`define LCR_DIM_PWM_SOURCE_SEL    3
`define LCR_RAMP_OUTPUT_SEL       4
`define LCR_AUTO_RETRY_OFF        5
`define LCR_FAULT_RESPONSE_SEL    6
`define LCR_DIM_PWM_OFF           7
// ----------------------------------------
// field positions, second register
// ----------------------------------------
`define LCR_USER_MEM_WRITE_ALLOW  0
`define LCR_DIM_RANGE_LSB         1
`define LCR_DIM_RANGE_MSB         2
// ----------------------------------------
// nonvolatile copy timing
// ----------------------------------------
`define LCR_NV_WRITE_NS           1000
`define LCR_CLK_NS                10
`define LCR_NV_WRITE_CYC          ((`LCR_NV_WRITE_NS + `LCR_CLK_NS - 1) / `LCR_CLK_NS)
`endif

// [rtl/lcr_sync2.v]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-flop synchroniser for pin inputs
// ----------------------------------------
module lcr_sync2 (
    input  wire clk_sys,
    input  wire reset,
    input  wire din,
    output wire dout
);
    reg meta_ff;
    reg sync_ff;

    // first flop read only by the second
    always @(posedge clk_sys) begin
        if (reset) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire

// [tb/lcr_config_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lcr_consts.vh"
module lcr_config_regs_monitor (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       shadow_nv_write_block,
    input wire logic       nv_wr_req,
    input wire logic       nv_busy,
    input wire logic       overcurrent_raw,
    input wire logic       overcurrent_fault,
    input wire logic [1:0] chan_fault,
    input wire logic [1:0] chan_disable,
    input wire logic       auto_retry_en,
    input wire logic       dim_osc_ext_clk,
    input wire logic       lamp_sync_pin_oe,
    input wire logic       dim_sync_pin_oe,
    input wire logic [1:0] dim_range
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ----
    // write strobes seen at the register port
    // ----
    sequence s_wr1; reg_wr && reg_addr == `LCR_ADDR_CFG1; endsequence
    sequence s_wr2; reg_wr && reg_addr == `LCR_ADDR_CFG2; endsequence
    sequence s_idle_copy; reg_wr && !nv_busy && (reg_addr == 8'hf4 || reg_addr == 8'hf5); endsequence
    // decoded controls follow the written byte one cycle later
    a_oc_gate: assert property (s_wr1 |=> overcurrent_fault == (overcurrent_raw && $past(reg_wdata[0]))) else $error("oc gate");
    a_osc_sel: assert property (s_wr1 |=> dim_osc_ext_clk == $past(reg_wdata[1])) else $error("osc sel");
    a_lamp_dir: assert property (s_wr1 |=> lamp_sync_pin_oe == !$past(reg_wdata[2])) else $error("lamp dir");
    a_dim_dir: assert property (s_wr1 |=> dim_sync_pin_oe == !$past(reg_wdata[3])) else $error("dim dir");
    a_retry_en: assert property (s_wr1 |=> auto_retry_en == !$past(reg_wdata[5])) else $error("retry");
    a_fault_resp: assert property (s_wr1 |=>
        chan_disable == (($past(reg_wdata[6]) && chan_fault != 2'b00) ? 2'b11 : chan_fault)) else $error("fault resp");
    a_range_sel: assert property (s_wr2 |=> dim_range == $past(reg_wdata[2:1])) else $error("range");
    // copy is a one-cycle pulse, and none at all while blocked
    a_nv_copy: assert property (s_idle_copy and !shadow_nv_write_block |=> nv_wr_req ##1 !nv_wr_req)
        else $error("nv copy");
    a_nv_block: assert property (s_idle_copy and shadow_nv_write_block |=> !nv_wr_req) else $error("nv block");
endmodule
bind lcr_config_regs lcr_config_regs_monitor u_lcr_config_regs_monitor (.*);
`default_nettype wire

// [tb/lcr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model (
    input  wire logic       clk_sys,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // released bus shows the inverse, so a stale value never passes
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one idle cycle after each access keeps strobes from re-rising in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1 reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1 d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(posedge clk_sys);
        #1;
    endtask
endmodule
`default_nettype wire

// [tb/lcr_config_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lcr_consts.vh"
module lcr_config_regs_bench;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, nv_wr_addr, nv_wr_data, nv_load_cfg1, nv_load_cfg2, v;
    logic [7:0] nv_cnt = 8'h00;
    logic [1:0] chan_fault, chan_disable, dim_range;
    logic clk_sys, reset, reg_wr, reg_rd, reg_hit, shadow_nv_write_block, nv_wr_req, nv_busy, nv_load;
    logic user_mem_wr_req, user_mem_wr_grant, overcurrent_raw, overcurrent_fault, auto_retry_en;
    logic dim_osc_ext_clk, dim_osc_pin, dim_ext_clk, lamp_freq_int, lamp_sync_pin_i, lamp_sync_pin_o;
    logic lamp_sync_pin_oe, lamp_freq, dim_pwm_int, ramp_int, dim_sync_pin_i, dim_sync_pin_o;
    logic dim_sync_pin_oe, burst_dimming_pwm;
    int   error_cnt = 0;
    int   cmp_count = 0;
    lcr_config_regs u_lcr_config_regs (.*);
    lcr_host_model  u_lcr_host_model (.*);
    // ----
    // compare and close
    // ----
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_cfg1();
        for (int i = 0; i < 8; i++) begin
            u_lcr_host_model.wr(8'hf4, 8'h01 << i);
            u_lcr_host_model.rd(8'hf4, v);
            chk(v, 8'h01 << i);
            // each control maps to one bit with raw oc and channel zero faulting
            chk({burst_dimming_pwm, chan_disable[1], ~auto_retry_en, dim_sync_pin_o, ~dim_sync_pin_oe,
                 ~lamp_sync_pin_oe, dim_osc_ext_clk, overcurrent_fault}, 8'h01 << i);
        end
        // pins turned round: external sources reach the core after the synchroniser
        u_lcr_host_model.wr(8'hf4, 8'h0e);
        lamp_sync_pin_i = 1'b1;
        dim_sync_pin_i = 1'b1;
        dim_osc_pin = 1'b1;
        lamp_freq_int = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk({lamp_freq, burst_dimming_pwm, dim_ext_clk}, 8'h07);
        chk({lamp_sync_pin_o, lamp_sync_pin_oe, dim_sync_pin_oe}, 8'h00);
        $display("t_cfg1 done");
    endtask
    task automatic t_cfg2();
        u_lcr_host_model.wr(8'hf5, 8'hff);
        // hit flag looked at while the read address stands
        fork
            u_lcr_host_model.rd(8'hf5, v);
            #2 chk(reg_hit, 8'h01);
        join
        chk(v, 8'h9f);
        user_mem_wr_req = 1'b1;
        // every range code, with the user memory write allow bit both clear and set
        for (int k = 0; k < 8; k++) begin
            u_lcr_host_model.wr(8'hf5, k[7:0]);
            chk({5'h00, dim_range, user_mem_wr_grant}, k[7:0]);
        end
        u_lcr_host_model.wr(8'hf6, 8'h5a);
        fork
            u_lcr_host_model.rd(8'hf6, v);
            #2 chk(reg_hit, 8'h00);
        join
        chk(v, 8'h00);
        // the unmapped write left the second register alone
        u_lcr_host_model.rd(8'hf5, v);
        chk(v, 8'h07);
        $display("t_cfg2 done");
    endtask
    task automatic t_nv();
        logic [7:0] n;
        repeat (110) @(posedge clk_sys);
        #1 shadow_nv_write_block = 1'b1;
        n = nv_cnt;
        u_lcr_host_model.wr(8'hf4, 8'h21);
        chk(nv_cnt, n);
        shadow_nv_write_block = 1'b0;
        u_lcr_host_model.wr(8'hf5, 8'h06);
        u_lcr_host_model.wr(8'hf4, 8'h42);
        chk(nv_cnt, n + 8'h01);
        chk(nv_wr_data, 8'h06);
        chk(nv_wr_addr, 8'hf5);
        // write during a busy copy still lands in the register
        u_lcr_host_model.rd(8'hf4, v);
        chk(v, 8'h42);
        $display("t_nv done");
    endtask
    task automatic t_reset();
        // mid-run reset returns both bytes to their reset values
        u_lcr_host_model.wr(8'hf4, 8'hff);
        u_lcr_host_model.wr(8'hf5, 8'hff);
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 reset = 1'b0;
        u_lcr_host_model.rd(8'hf4, v);
        chk(v, `LCR_CFG1_RESET);
        u_lcr_host_model.rd(8'hf5, v);
        chk(v, `LCR_CFG2_RESET);
        // internal sources back in use while the pins still sit high
        chk({lamp_sync_pin_oe, dim_sync_pin_oe, auto_retry_en, lamp_freq, burst_dimming_pwm}, 8'h1c);
        $display("t_reset done");
    endtask
    task automatic t_recall();
        // power-up recall loads both bytes, reserved bits of the second stay clear
        nv_load_cfg1 = 8'h5a;
        nv_load_cfg2 = 8'hff;
        nv_load = 1'b1;
        @(posedge clk_sys);
        #1 nv_load = 1'b0;
        u_lcr_host_model.rd(8'hf4, v);
        chk(v, 8'h5a);
        u_lcr_host_model.rd(8'hf5, v);
        chk(v, 8'h9f);
        $display("t_recall done");
    endtask
    // count copy pulses at the edge they are sampled
    always @(posedge clk_sys) if (nv_wr_req === 1'b1) nv_cnt <= nv_cnt + 8'h01;
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #100000;
        error_cnt++;
        results();
    end
    initial begin
        {reset, overcurrent_raw, chan_fault, ramp_int, lamp_freq_int} = 6'h3f;
        chan_fault = 2'b01;
        {shadow_nv_write_block, nv_load, user_mem_wr_req, dim_osc_pin, dim_pwm_int} = 5'h00;
        {lamp_sync_pin_i, dim_sync_pin_i, nv_load_cfg1, nv_load_cfg2} = 18'h0;
        repeat (5) @(posedge clk_sys);
        #1 reset = 1'b0;
        u_lcr_host_model.rd(8'hf4, v);
        chk(v, 8'h00);
        t_cfg1();
        t_cfg2();
        t_nv();
        t_reset();
        t_recall();
        results();
    end
endmodule
`default_nettype wire
